// ---- spi_master_slave_port.sv ----
// Notes on behaviour
// - Codes 000-010: master, fsys over 4/16/64
// - Code 011 sub clock, 100 timer match/2
// - 101 slave, 110 two-wire, 111 off
// - Master starts transfers; slave follows clock
// - Full duplex: bit out, bit in
// - Disabled: lines released, activity stopped
// - Enabling keeps control settings unchanged
// - Select enable: select pin used, else floating
// - One select pin; more slaves via GPIO
// - One data register for send and receive
// - Software picks LSB or MSB first
// - Software picks active clock edge
// - Early select release sets incomplete and complete
// - Software setting incomplete leaves complete alone
// - Incomplete flag slave only; raises request
// - Debounce bits have no effect here
// - Mode register bit 4 reads zero
// - Complete flag set by hardware, cleared by software
// - Write while busy ignored, sets collision
// - Polarity 1 idles low, 0 idles high
// - Order bit 1 MSB first, 0 LSB
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire spi_port_pkg::regReq_t busReq,
  output logic [7:0]                rdData,
  input  wire logic                 subClkPin,
  input  wire logic                 ptmMatch,
  input  wire logic                 sdiPin,
  input  wire logic                 sckIn,
  output logic                      sckOut,
  output logic                      sckOe,
  output logic                      sdoOut,
  output logic                      sdoOe,
  input  wire logic                 scsIn,
  output logic                      scsOut,
  output logic                      scsOe,
  output logic                      irqReq
);
  logic [2:0]            modeField_ff;
  logic [1:0]            debounce_ff;
  logic                  enable_ff;
  logic                  icf_ff;
  logic [1:0]            spare_ff;
  logic                  pol_ff;
  logic                  edge_ff;
  logic                  order_ff;
  logic                  select_pin_enable_ff;
  logic                  write_collision_flag_ff;
  logic                  trf_ff;
  logic [7:0]            shr_ff;
  logic [3:0]            sync1_ff;
  logic [3:0]            sync2_ff;
  logic                  sckDly_ff;
  logic                  scsDly_ff;
  logic                  subDly_ff;
  spi_port_pkg::mstate_t mState_ff;
  logic [5:0]            divCnt_ff;
  logic [4:0]            edgeCnt_ff;
  logic [3:0]            bitCnt_ff;
  logic                  sck_ff;
  logic                  sckOe_ff;
  logic                  sdo_ff;
  logic                  sdoOe_ff;
  logic                  scsOut_ff;
  logic                  scsOe_ff;
  logic                  irq_ff;
  logic [7:0]            rdData_ff;

  spi_port_pkg::mode_t mode;
  logic       isMaster, isSlave, idleLvl;
  logic       sdiS, sckS, scsS, subS, selected;
  logic [5:0] halfCnt;
  logic       srcTick, mTick, mLead, slvEdge, anyEdge, lead;
  logic       sampleEdge, launchEdge, busy, wordDone;
  logic       wrMode, wrFmt, wrData, dataOk, collide;
  logic       scsRise, scsFall, icfEvent, mStart;

  function automatic logic outBit(input logic [7:0] v, input logic msbFirst);
    outBit = msbFirst ? v[7] : v[0];
  endfunction : outBit

  // Decoding of mode and enable
  assign mode     = spi_port_pkg::mode_t'(modeField_ff);
  assign isMaster = enable_ff && (modeField_ff <= spi_port_pkg::MODE_TIMER);
  assign isSlave  = enable_ff && (mode == spi_port_pkg::MODE_SLAVE);
  assign idleLvl  = ~pol_ff;

  // Register strobes
  assign wrMode = busReq.wr && (busReq.addr == spi_port_pkg::MODE_CTRL_OFS);
  assign wrFmt  = busReq.wr && (busReq.addr == spi_port_pkg::FORMAT_CTRL_OFS);
  assign wrData = busReq.wr && (busReq.addr == spi_port_pkg::DATA_OFS);

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 4'h4; // Select idles high, so no false edge after reset
      sync2_ff <= 4'h4;
      sckDly_ff <= 1'b0;
      scsDly_ff <= 1'b1;
      subDly_ff <= 1'b0;
    end else begin
      sync1_ff  <= {subClkPin, scsIn, sckIn, sdiPin};
      sync2_ff  <= sync1_ff;
      sckDly_ff <= sync2_ff[1];
      scsDly_ff <= sync2_ff[2];
      subDly_ff <= sync2_ff[3];
    end
  end
  assign sdiS = sync2_ff[0];
  assign sckS = sync2_ff[1];
  assign scsS = sync2_ff[2];
  assign subS = sync2_ff[3];
  assign selected = !select_pin_enable_ff || !scsS;

  // Master bit clock source
  always_comb begin
    case (mode)
      spi_port_pkg::MODE_DIV4:  halfCnt = spi_port_pkg::HALF_FAST;
      spi_port_pkg::MODE_DIV16: halfCnt = spi_port_pkg::HALF_MID;
      default:                  halfCnt = spi_port_pkg::HALF_SLOW;
    endcase
    case (mode)
      spi_port_pkg::MODE_SUB:   srcTick = subS != subDly_ff;
      spi_port_pkg::MODE_TIMER: srcTick = ptmMatch;
      default:                  srcTick = divCnt_ff == halfCnt - 6'h01;
    endcase
  end

  // Edge events shared by both roles; slave edges come only from the pin
  assign mTick      = isMaster && (mState_ff == spi_port_pkg::M_SHIFT) && srcTick;
  assign mLead      = sck_ff == idleLvl;
  assign slvEdge    = isSlave && selected && (sckS != sckDly_ff);
  assign anyEdge    = mTick || slvEdge;
  assign lead       = isMaster ? mLead : (sckS != idleLvl);
  assign sampleEdge = anyEdge && (lead != edge_ff);
  assign launchEdge = anyEdge && (lead == edge_ff);
  assign busy       = isMaster ? (mState_ff == spi_port_pkg::M_SHIFT) : (bitCnt_ff != 4'h0);
  assign wordDone   = isMaster ? (mTick && edgeCnt_ff == spi_port_pkg::LAST_EDGE)
                               : (sampleEdge && bitCnt_ff == spi_port_pkg::LAST_BIT);
  assign dataOk     = wrData && !busy && !sampleEdge;
  assign collide    = wrData && !dataOk;
  assign mStart     = dataOk && isMaster;
  assign scsRise    = isSlave && select_pin_enable_ff && scsS && !scsDly_ff;
  assign scsFall    = isSlave && select_pin_enable_ff && !scsS && scsDly_ff;
  assign icfEvent   = scsRise && (bitCnt_ff != 4'h0);

  // Mode control register; enabling reloads nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      modeField_ff <= spi_port_pkg::MODE_RST;
      debounce_ff  <= 2'h0;
      enable_ff    <= 1'b0;
    end else if (wrMode) begin
      modeField_ff <= busReq.wdata[spi_port_pkg::MODE_LSB +: 3];
      debounce_ff  <= busReq.wdata[spi_port_pkg::DEB_LSB +: 2];
      enable_ff    <= busReq.wdata[spi_port_pkg::EN_BIT];
    end
  end

  // Incomplete flag: set by hardware wins over a software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      icf_ff <= 1'b0;
    end else if (icfEvent) begin
      icf_ff <= 1'b1;
    end else if (wrMode) begin
      icf_ff <= busReq.wdata[spi_port_pkg::ICF_BIT];
    end
  end

  // Format control settings
  always_ff @(posedge clk) begin
    if (rst) begin
      spare_ff <= spi_port_pkg::FMT_RST[spi_port_pkg::SPARE_LSB +: 2];
      pol_ff   <= spi_port_pkg::FMT_RST[spi_port_pkg::POL_BIT];
      edge_ff  <= spi_port_pkg::FMT_RST[spi_port_pkg::EDGE_BIT];
      order_ff <= spi_port_pkg::FMT_RST[spi_port_pkg::ORDER_BIT];
      select_pin_enable_ff  <= spi_port_pkg::FMT_RST[spi_port_pkg::SELECT_PIN_ENABLE_BIT];
    end else if (wrFmt) begin
      spare_ff <= busReq.wdata[spi_port_pkg::SPARE_LSB +: 2];
      pol_ff   <= busReq.wdata[spi_port_pkg::POL_BIT];
      edge_ff  <= busReq.wdata[spi_port_pkg::EDGE_BIT];
      order_ff <= busReq.wdata[spi_port_pkg::ORDER_BIT];
      select_pin_enable_ff  <= busReq.wdata[spi_port_pkg::SELECT_PIN_ENABLE_BIT];
    end
  end

  // Completion and collision flags; a hardware set beats a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      trf_ff  <= 1'b0;
      write_collision_flag_ff <= 1'b0;
    end else begin
      if (wordDone || icfEvent) begin
        trf_ff <= 1'b1;
      end else if (wrFmt) begin
        trf_ff <= busReq.wdata[spi_port_pkg::TRF_BIT];
      end
      if (collide) begin
        write_collision_flag_ff <= 1'b1;
      end else if (wrFmt) begin
        write_collision_flag_ff <= busReq.wdata[spi_port_pkg::WRITE_COLLISION_FLAG_BIT];
      end
    end
  end

  // Shared data register doubles as the shift register
  always_ff @(posedge clk) begin
    if (rst) begin
      shr_ff <= spi_port_pkg::DATA_RST;
    end else if (dataOk) begin
      shr_ff <= busReq.wdata;
    end else if (sampleEdge) begin
      shr_ff <= order_ff ? {shr_ff[6:0], sdiS} : {sdiS, shr_ff[7:1]};
    end
  end

  // Master sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      mState_ff  <= spi_port_pkg::M_IDLE;
      edgeCnt_ff <= 5'h00;
    end else if (!isMaster) begin
      mState_ff  <= spi_port_pkg::M_IDLE;
      edgeCnt_ff <= 5'h00;
    end else begin
      case (mState_ff)
        spi_port_pkg::M_IDLE: begin
          edgeCnt_ff <= 5'h00;
          if (mStart) begin
            mState_ff <= spi_port_pkg::M_SHIFT;
          end
        end
        spi_port_pkg::M_SHIFT: begin
          if (mTick) begin
            edgeCnt_ff <= edgeCnt_ff + 5'h01;
            if (wordDone) begin
              mState_ff <= spi_port_pkg::M_IDLE;
            end
          end
        end
        default: mState_ff <= spi_port_pkg::M_IDLE;
      endcase
    end
  end

  // Divider restarts with each transfer so the first half period is whole
  always_ff @(posedge clk) begin
    if (rst) begin
      divCnt_ff <= 6'h00;
    end else if (!isMaster || mState_ff != spi_port_pkg::M_SHIFT || srcTick) begin
      divCnt_ff <= 6'h00;
    end else begin
      divCnt_ff <= divCnt_ff + 6'h01;
    end
  end

  // Slave bit counter, restarted on each new selection
  always_ff @(posedge clk) begin
    if (rst) begin
      bitCnt_ff <= 4'h0;
    end else if (!isSlave || scsRise || scsFall) begin
      bitCnt_ff <= 4'h0;
    end else if (sampleEdge) begin
      bitCnt_ff <= wordDone ? 4'h0 : bitCnt_ff + 4'h1;
    end
  end

  // Serial clock: master only, parked at the idle level
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_ff   <= 1'b1;
      sckOe_ff <= 1'b0;
    end else begin
      sckOe_ff <= isMaster;
      if (!isMaster || mState_ff == spi_port_pkg::M_IDLE) begin
        sck_ff <= idleLvl;
      end else if (mTick) begin
        sck_ff <= ~sck_ff;
      end
    end
  end

  // Data output; first bit is ready before the first clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      sdo_ff   <= 1'b0;
      sdoOe_ff <= 1'b0;
    end else begin
      sdoOe_ff <= isMaster || (isSlave && selected);
      if (dataOk) begin
        sdo_ff <= outBit(busReq.wdata, order_ff);
      end else if (launchEdge || scsFall) begin
        sdo_ff <= outBit(shr_ff, order_ff);
      end
    end
  end

  // Single select pin; driven low by a master only during a word
  always_ff @(posedge clk) begin
    if (rst) begin
      scsOut_ff <= 1'b1;
      scsOe_ff  <= 1'b0;
    end else begin
      scsOe_ff  <= isMaster && select_pin_enable_ff;
      scsOut_ff <= !(mStart || (isMaster && mState_ff == spi_port_pkg::M_SHIFT && !wordDone));
    end
  end

  // Request toward the interrupt controller, which holds the enable
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= trf_ff || icf_ff;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_ff <= 8'h00;
    end else if (busReq.rd) begin
      case (busReq.addr)
        spi_port_pkg::MODE_CTRL_OFS:
          rdData_ff <= {modeField_ff, 1'b0, debounce_ff, enable_ff, icf_ff};
        spi_port_pkg::FORMAT_CTRL_OFS:
          rdData_ff <= {spare_ff, pol_ff, edge_ff, order_ff, select_pin_enable_ff, write_collision_flag_ff, trf_ff};
        spi_port_pkg::DATA_OFS:
          rdData_ff <= shr_ff;
        default:
          rdData_ff <= 8'h00;
      endcase
    end else begin
      rdData_ff <= 8'h00;
    end
  end

  assign rdData = rdData_ff;
  assign sckOut = sck_ff;
  assign sckOe  = sckOe_ff;
  assign sdoOut = sdo_ff;
  assign sdoOe  = sdoOe_ff;
  assign scsOut = scsOut_ff;
  assign scsOe  = scsOe_ff;
  assign irqReq = irq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  idle_clock_level_a: assert property (
    (mState_ff == spi_port_pkg::M_IDLE && $past(mState_ff) == spi_port_pkg::M_IDLE
     && $stable(pol_ff) && $stable(enable_ff)) |-> sck_ff == ~pol_ff)
    else $error("idle clock not at polarity level");
  disabled_release_a: assert property (
    !enable_ff |=> !sckOe && !sdoOe && !scsOe)
    else $error("lines driven while disabled");
  fast_half_period_a: assert property (
    (mTick && mode == spi_port_pkg::MODE_DIV4 && edgeCnt_ff < 5'h0e && $stable(modeField_ff))
    |=> !mTick ##1 mTick)
    else $error("fsys/4 half period wrong");
  word_done_flag_a: assert property (
    (mTick && edgeCnt_ff == 5'h0f) |=> trf_ff && mState_ff == spi_port_pkg::M_IDLE
    && sck_ff == ~pol_ff)
    else $error("master word end wrong");
  collision_ignored_a: assert property (
    (wrData && busy) |=> write_collision_flag_ff && (shr_ff != $past(busReq.wdata) || $past(shr_ff) ==
     $past(busReq.wdata) || $past(sampleEdge)))
    else $error("busy write not ignored");
  incomplete_sets_a: assert property (
    icfEvent |=> icf_ff && trf_ff && bitCnt_ff == 4'h0)
    else $error("early deselect flags missing");
  sw_incomplete_a: assert property (
    (wrMode && busReq.wdata[0] && !trf_ff && !wrFmt && !wordDone && !icfEvent)
    |=> icf_ff && !trf_ff)
    else $error("software incomplete set complete");
  first_bit_order_a: assert property (
    mStart |=> sdo_ff == ($past(order_ff) ? $past(busReq.wdata[7]) : $past(busReq.wdata[0])))
    else $error("first bit order wrong");
  slave_no_clock_a: assert property (
    isSlave |=> !sckOe)
    else $error("slave drives clock");
  reserved_bit_a: assert property (
    (busReq.rd && busReq.addr == spi_port_pkg::MODE_CTRL_OFS) |=> rdData[4] == 1'b0)
    else $error("reserved bit reads one");
endmodule : spi_master_slave_port
`default_nettype wire

// ---- spi_master_slave_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port_test;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  spi_port_pkg::regReq_t busReq = '0;
  logic [7:0]            rdData, ptx, prx, tx, got;
  logic                  subClkPin = 1'b0, ptmMatch = 1'b0, benchMaster = 1'b0;
  logic                  sdiB = 1'b0, sckB = 1'b0, scsB = 1'b1, pol = 1'b0, edg = 1'b0;
  logic                  sckOut, sckOe, sdoOut, sdoOe, scsOut, scsOe, irqReq, peerSdi;
  logic                  rdSeen = 1'b0;
  logic [7:0]            expQ[$];
  int                    errorCnt = 0, numChecks = 0, cyc = 0, seed = 42573;
  int                    n, k, m, h, subCnt = 0, ptmCnt = 0;
  int                    halves[5] = '{2, 8, 32, 7, 10};
  // Pin level: whoever enables its driver wins, bench side otherwise
  wire logic             sckW = sckOe ? sckOut : sckB;
  wire logic             scsW = scsOe ? scsOut : scsB;

  spi_master_slave_port spi_master_slave_port_inst (
    .clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData),
    .subClkPin(subClkPin), .ptmMatch(ptmMatch), .sdiPin(benchMaster ? sdiB : peerSdi),
    .sckIn(sckW), .sckOut(sckOut), .sckOe(sckOe), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .scsIn(scsW), .scsOut(scsOut), .scsOe(scsOe), .irqReq(irqReq)
  );

  spi_peer_model spi_peer_model_inst (
    .sck(sckW), .selN(scsW), .sdo(sdoOut), .sampleRise(pol ^ edg),
    .txByte(ptx), .sdi(peerSdi), .rxByte(prx)
  );

  always #5 clk = ~clk;

  // Sub clock toggles every 7 cycles, timer match pulses every 10
  always @(posedge clk) begin
    subCnt   <= (subCnt == 6) ? 0 : subCnt + 1;
    ptmCnt   <= (ptmCnt == 9) ? 0 : ptmCnt + 1;
    ptmMatch <= (ptmCnt == 9);
    if (subCnt == 6) subClkPin <= ~subClkPin;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rdSeen) check("rdData", rdData, expQ.pop_front());
    rdSeen <= busReq.rd;
  end

  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      endOfTest();
    end
  end

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    busReq <= '0;
  endtask : wr

  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    expQ.push_back(e);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
  endtask : rd

  task waitIrq;
    n = 0;
    while (irqReq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check("irqReq", {7'h0, irqReq}, 8'h01);
  endtask : waitIrq

  // Cycles between the first two clock toggles after a start
  task half;
    logic s;
    s = sckOut;
    n = 0;
    while (sckOut === s && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    s = sckOut;
    h = 0;
    while (sckOut === s && h < 200) begin
      @(posedge clk);
      #1;
      h++;
    end
  endtask : half

  // Bench as master: sample on rising, half period 6 cycles (sync needs 3)
  task sframe(input int nb, input logic [7:0] w);
    int i;
    got = 8'h00;
    @(posedge clk);
    scsB <= 1'b0;
    repeat (6) @(posedge clk);
    check("sdoOe", {7'h0, sdoOe}, 8'h01);
    for (i = 0; i < nb; i++) begin
      sdiB <= w[7 - i];
      repeat (6) @(posedge clk);
      sckB <= 1'b1;
      got = {got[6:0], sdoOut};
      repeat (6) @(posedge clk);
      sckB <= 1'b0;
    end
    repeat (6) @(posedge clk);
    scsB <= 1'b1;
    sdiB <= ~sdiB;
  endtask : sframe

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction : rev8

  task endOfTest;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : endOfTest

  // Main sequence
  initial begin
    logic [7:0] f;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    check("oeRst", {5'h0, sckOe, sdoOe, scsOe}, 8'h00);
    rd(spi_port_pkg::MODE_CTRL_OFS, 8'he0);
    rd(spi_port_pkg::FORMAT_CTRL_OFS, 8'h00);
    rd(spi_port_pkg::DATA_OFS, 8'h00);
    rd(2'h3, 8'h00);
    wr(spi_port_pkg::MODE_CTRL_OFS, 8'hfc);
    rd(spi_port_pkg::MODE_CTRL_OFS, 8'hec);
    $display("test registers done");
    // Every polarity, edge and order; a second data write collides
    for (k = 0; k < 8; k++) begin
      f = {2'b00, k[2], k[1], k[0], 3'b100};
      pol = k[2];
      edg = k[1];
      tx = 8'($random(seed));
      ptx = 8'($random(seed));
      wr(spi_port_pkg::FORMAT_CTRL_OFS, f);
      wr(spi_port_pkg::MODE_CTRL_OFS, 8'h22);
      wr(spi_port_pkg::DATA_OFS, tx);
      wr(spi_port_pkg::DATA_OFS, ~tx);
      waitIrq();
      rd(spi_port_pkg::DATA_OFS, k[0] ? ptx : rev8(ptx));
      rd(spi_port_pkg::FORMAT_CTRL_OFS, f | 8'h03);
      check("peerRx", prx, k[0] ? tx : rev8(tx));
      check("sckIdle", {7'h0, sckOut}, {7'h0, ~k[2]});
      wr(spi_port_pkg::FORMAT_CTRL_OFS, f);
    end
    $display("test master transfers done");
    pol = 1'b0;
    edg = 1'b0;
    wr(spi_port_pkg::FORMAT_CTRL_OFS, 8'h04);
    for (m = 0; m < 5; m++) begin
      wr(spi_port_pkg::MODE_CTRL_OFS, {m[2:0], 5'h02});
      wr(spi_port_pkg::DATA_OFS, 8'($random(seed)));
      half();
      check("sckHalf", 8'(h), 8'(halves[m]));
      waitIrq();
      wr(spi_port_pkg::FORMAT_CTRL_OFS, 8'h04);
    end
    $display("test clock sources done");
    foreach (halves[i]) begin
      if (i < 3) begin
        wr(spi_port_pkg::MODE_CTRL_OFS, (i == 0) ? 8'h20 : ((i == 1) ? 8'he2 : 8'hc2));
        repeat (3) @(posedge clk);
        #1;
        check("oeOff", {5'h0, sckOe, sdoOe, scsOe}, 8'h00);
      end
    end
    wr(spi_port_pkg::MODE_CTRL_OFS, 8'h22);
    rd(spi_port_pkg::FORMAT_CTRL_OFS, 8'h04);
    // Select enable off: the select pin is left floating
    wr(spi_port_pkg::FORMAT_CTRL_OFS, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check("scsOeOff", {5'h0, sckOe, sdoOe, scsOe}, 8'h06);
    $display("test disable done");
    // Slave: full word, then a word cut short by the select line
    benchMaster <= 1'b1;
    tx = 8'($random(seed));
    ptx = 8'($random(seed));
    wr(spi_port_pkg::FORMAT_CTRL_OFS, 8'h2c);
    wr(spi_port_pkg::MODE_CTRL_OFS, 8'hb2);
    wr(spi_port_pkg::DATA_OFS, tx);
    repeat (4) @(posedge clk);
    check("sdoOeIdle", {7'h0, sdoOe}, 8'h00);
    sframe(8, ptx);
    rd(spi_port_pkg::DATA_OFS, ptx);
    check("slaveTx", got, tx);
    rd(spi_port_pkg::FORMAT_CTRL_OFS, 8'h2d);
    wr(spi_port_pkg::FORMAT_CTRL_OFS, 8'h2c);
    sframe(3, ptx);
    repeat (6) @(posedge clk);
    rd(spi_port_pkg::MODE_CTRL_OFS, 8'ha3);
    rd(spi_port_pkg::FORMAT_CTRL_OFS, 8'h2d);
    check("irqIcf", {7'h0, irqReq}, 8'h01);
    wr(spi_port_pkg::MODE_CTRL_OFS, 8'hb2);
    wr(spi_port_pkg::FORMAT_CTRL_OFS, 8'h2c);
    wr(spi_port_pkg::MODE_CTRL_OFS, 8'hb3);
    repeat (3) @(posedge clk);
    rd(spi_port_pkg::FORMAT_CTRL_OFS, 8'h2c);
    $display("test slave done");
    endOfTest();
  end
endmodule : spi_master_slave_port_test
`default_nettype wire

// ---- spi_peer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
  input  wire logic       sck,
  input  wire logic       selN,
  input  wire logic       sdo,
  input  wire logic       sampleRise,
  input  wire logic [7:0] txByte,
  output logic            sdi,
  output logic [7:0]      rxByte
);
  int   idx  = 0;
  logic drv  = 1'b0;
  logic sckQ = 1'b0;
  logic selQ = 1'b1;

  // Released line shows the inverse, so a stale bit is never mistaken
  assign sdi = selN ? ~drv : drv;

  // One process for the peer; selQ lags by a time step, so a clock edge
  // that shares its step with the select release still counts
  always @(sck or selN) begin
    if (selQ === 1'b1 && selN === 1'b0) begin
      idx    = 0;
      drv    = txByte[7];
      rxByte = 8'h00;
    end
    if (sck !== sckQ && selQ === 1'b0) begin
      if (sck === sampleRise) begin
        rxByte = {rxByte[6:0], sdo};
        idx    = idx + 1;
      end else if (idx < 8) begin
        drv = txByte[7 - idx];
      end
    end
    sckQ = sck;
    selQ <= selN;
  end
endmodule : spi_peer_model
`default_nettype wire

// ---- spi_port_pkg.sv ----
`default_nettype none
package spi_port_pkg;
  // Register offsets on the plain register port
  localparam logic [1:0] MODE_CTRL_OFS   = 2'h0;
  localparam logic [1:0] FORMAT_CTRL_OFS = 2'h1;
  localparam logic [1:0] DATA_OFS        = 2'h2;

  // Mode control field positions
  localparam int MODE_LSB  = 5;
  localparam int DEB_LSB   = 2;
  localparam int EN_BIT    = 1;
  localparam int ICF_BIT   = 0;
  // Format control field positions
  localparam int SPARE_LSB = 6;
  localparam int POL_BIT   = 5;
  localparam int EDGE_BIT  = 4;
  localparam int ORDER_BIT = 3;
  localparam int SELECT_PIN_ENABLE_BIT  = 2;
  localparam int WRITE_COLLISION_FLAG_BIT  = 1;
  localparam int TRF_BIT   = 0;

  // Reset values
  localparam logic [2:0] MODE_RST  = 3'h7;
  localparam logic [7:0] FMT_RST   = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;

  // Clock dividers and the half periods derived from them
  localparam int DIV_FAST = 4;
  localparam int DIV_MID  = 16;
  localparam int DIV_SLOW = 64;
  localparam logic [5:0] HALF_FAST = 6'(DIV_FAST / 2);
  localparam logic [5:0] HALF_MID  = 6'(DIV_MID / 2);
  localparam logic [5:0] HALF_SLOW = 6'(DIV_SLOW / 2);

  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [4:0] LAST_EDGE = 5'h0f;

  typedef enum logic [2:0] {
    MODE_DIV4   = 3'b000,
    MODE_DIV16  = 3'b001,
    MODE_DIV64  = 3'b010,
    MODE_SUB    = 3'b011,
    MODE_TIMER  = 3'b100,
    MODE_SLAVE  = 3'b101,
    MODE_TWOWIRE = 3'b110,
    MODE_OFF    = 3'b111
  } mode_t;

  typedef enum logic [0:0] {
    M_IDLE  = 1'b0,
    M_SHIFT = 1'b1
  } mstate_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } regReq_t;
endpackage : spi_port_pkg
`default_nettype wire
